/* File: rtl/mst_pkg.sv */
// Package for the machine status and trap register block
package mst_pkg;

  // Register offsets (word index on the register port)
  localparam logic [11:0] ADDR_STATUS = 12'h300;
  localparam logic [11:0] ADDR_ISA = 12'h301;
  localparam logic [11:0] ADDR_EXC_DELEG = 12'h302;
  localparam logic [11:0] ADDR_INT_DELEG = 12'h303;
  localparam logic [11:0] ADDR_INT_ENABLE = 12'h304;

  // Status register fields
  localparam int ST_SRET_TRAP = 22;
  localparam int ST_WAIT_TRAP = 21;
  localparam int ST_VM_OP_TRAP = 20;
  localparam int ST_EXEC_READ = 19;
  localparam int ST_SUP_USER = 18;
  localparam int ST_MOD_PRIV = 17;
  localparam int ST_EXT_ST_LO = 15;
  localparam int ST_FLT_ST_LO = 13;
  localparam int ST_M_PRIOR_LO = 11;
  localparam int ST_S_PRIOR = 8;
  localparam int ST_M_PRIOR_IE = 7;
  localparam int ST_S_PRIOR_IE = 5;
  localparam int ST_U_PRIOR_IE = 4;
  localparam int ST_M_INT_EN = 3;
  localparam int ST_S_INT_EN = 1;
  localparam int ST_U_INT_EN = 0;
  localparam int ST_ANY_DIRTY = 31;
  localparam logic [31:0] STATUS_WMASK = 32'h007E79BB;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;

  // ISA report fields
  localparam int ISA_BASE_LO = 30;
  localparam logic [1:0] BASE_W32 = 2'h1;
  localparam logic [1:0] BASE_W64 = 2'h2;
  localparam logic [1:0] BASE_W128 = 2'h3;
  localparam logic [31:0] ISA_RESET = 32'h00000000;

  // Interrupt enable / pending layout
  localparam int IE_MEI = 11;
  localparam int IE_SEI = 9;
  localparam int IE_UEI = 8;
  localparam int IE_MTI = 7;
  localparam int IE_STI = 5;
  localparam int IE_UTI = 4;
  localparam int IE_MSI = 3;
  localparam int IE_SSI = 1;
  localparam int IE_USI = 0;
  localparam logic [31:0] IE_WMASK = 32'h00000BBB;
  localparam logic [31:0] DELEG_RESET = 32'h00000000;
  localparam logic [31:0] IE_RESET = 32'h00000000;

  // Exception cause codes
  localparam logic [4:0] CAUSE_ILLEGAL = 5'h02;
  localparam logic [4:0] CAUSE_ECALL_U = 5'h08;
  localparam logic [4:0] CAUSE_ECALL_S = 5'h09;
  localparam logic [4:0] CAUSE_IPF = 5'h0C;
  localparam logic [4:0] CAUSE_LPF = 5'h0D;
  localparam logic [4:0] CAUSE_SPF = 5'h0F;

  // Privilege and extension-state encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam logic [1:0] XST_OFF = 2'h0;
  localparam logic [1:0] XST_INITIAL = 2'h1;
  localparam logic [1:0] XST_CLEAN = 2'h2;
  localparam logic [1:0] XST_DIRTY = 2'h3;

endpackage : mst_pkg

/* File: rtl/mst_csr.sv */
// Machine status, ISA report, delegation and interrupt-enable registers
//
// Overview of operation
// - vm_op_trap set: S-mode translation access or VM fences are illegal.
// - exec_readable 1: loads succeed from readable or executable pages.
// - exec_readable has no effect without page-based translation.
// - supervisor_user_access 0: S-mode user-page loads and stores fault; 1 allows.
// - Same bit applies with modify_privilege set and prior privilege S.
// - modify_privilege 1: loads and stores use machine_prior_privilege.
// - Instruction fetch always uses the current privilege mode.
// - extension_state: 00 off, 01 initial, 10 clean, 11 dirty.
// - float_state tracks float register state with the same encoding.
// - Traps save the prior privilege in the target mode's prior field.
// - Traps save the target mode's enable into its prior enable bit.
// - Global enable bits gate interrupts taken into their own mode.
// - ISA report holds base width in bits 31:30; bits 29:26 read zero.
// - ISA report bits 25:0 flag present extensions, one per letter.
// - Exception delegation bit per cause code routes exception to S-mode.
// - Interrupt delegation bits follow pending layout, route to S-mode.
// - Machine external, timer, software enables sit at bits 11, 7, 3.
// - Supervisor external, timer, software enables sit at bits 9, 5, 1.
// - User external, timer, software enables sit at bits 8, 4, 0.
// - Status fields at 20, 19, 18, 17, 16:15, 14:13, 12:11.
// - Pending bits at 11, 7, 3 for machine external, timer, software.
// - Delegation indexes use causes 2, 8, 9, 12, 13, 15.
module mst_csr #(
  parameter logic [1:0] BASE_WIDTH = mst_pkg::BASE_W32,
  parameter logic [25:0] EXTENSIONS = 26'h0141105
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Hart state
  input wire logic [1:0] i_priv,
  input wire logic i_float_dirty,
  input wire logic [1:0] i_ext_state,
  // Trap entry and return
  input wire logic i_trap,
  input wire logic i_trap_irq,
  input wire logic [4:0] i_trap_cause,
  input wire logic i_mret,
  input wire logic i_sret,
  output logic o_trap_to_s,
  output logic [1:0] o_next_priv,
  // Virtual-memory operation check
  input wire logic i_satp_access,
  input wire logic i_vm_fence,
  output logic o_vm_illegal,
  // Memory permission check
  input wire logic i_paging_on,
  input wire logic i_is_fetch,
  input wire logic i_is_load,
  input wire logic i_is_store,
  input wire logic i_pte_r,
  input wire logic i_pte_w,
  input wire logic i_pte_x,
  input wire logic i_pte_u,
  output logic [1:0] o_eff_priv,
  output logic o_access_fault,
  // Interrupts
  input wire logic [31:0] i_pending,
  output logic o_irq_take,
  output logic [4:0] o_irq_cause,
  output logic o_irq_to_s
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] status;
  logic [31:0] next_status;
  logic [31:0] isa;
  logic [31:0] next_isa;
  logic [31:0] exc_deleg;
  logic [31:0] next_exc_deleg;
  logic [31:0] int_deleg;
  logic [31:0] next_int_deleg;
  logic [31:0] int_enable;
  logic [31:0] next_int_enable;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic deleg_hit;
  logic [31:0] status_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Trap routing

  always_comb
  begin
    // Never delegate away from M-mode itself
    if (i_trap_irq)
    begin
      deleg_hit = int_deleg[i_trap_cause];
    end
    else
    begin
      deleg_hit = exc_deleg[i_trap_cause];
    end
    o_trap_to_s = i_trap && deleg_hit && (i_priv != mst_pkg::PRIV_M);
  end

  always_comb
  begin
    if (i_trap)
    begin
      o_next_priv = o_trap_to_s ? mst_pkg::PRIV_S : mst_pkg::PRIV_M;
    end
    else if (i_mret)
    begin
      o_next_priv = status[mst_pkg::ST_M_PRIOR_LO +: 2];
    end
    else if (i_sret)
    begin
      o_next_priv = {1'b0, status[mst_pkg::ST_S_PRIOR]};
    end
    else
    begin
      o_next_priv = i_priv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Virtual-memory and permission checks

  always_comb
  begin
    o_vm_illegal = status[mst_pkg::ST_VM_OP_TRAP]
      && (i_priv == mst_pkg::PRIV_S)
      && (i_satp_access || i_vm_fence);
  end

  always_comb
  begin
    logic readable;
    logic sum_on;
    readable = 1'b0;
    sum_on = 1'b0;
    // Fetch ignores modify_privilege
    if (status[mst_pkg::ST_MOD_PRIV] && !i_is_fetch)
    begin
      o_eff_priv = status[mst_pkg::ST_M_PRIOR_LO +: 2];
    end
    else
    begin
      o_eff_priv = i_priv;
    end
    readable = i_pte_r
      || (status[mst_pkg::ST_EXEC_READ] && i_pte_x);
    sum_on = status[mst_pkg::ST_SUP_USER]
      && (o_eff_priv == mst_pkg::PRIV_S);
    o_access_fault = 1'b0;
    // Without paging no page check applies
    if (i_paging_on && o_eff_priv != mst_pkg::PRIV_M)
    begin
      if (i_is_fetch)
      begin
        o_access_fault = !i_pte_x || (i_priv == mst_pkg::PRIV_S && i_pte_u)
          || (i_priv == mst_pkg::PRIV_U && !i_pte_u);
      end
      else
      begin
        o_access_fault = (i_is_load && !readable) || (i_is_store && !i_pte_w)
          || (o_eff_priv == mst_pkg::PRIV_U && !i_pte_u)
          || (o_eff_priv == mst_pkg::PRIV_S && i_pte_u && !sum_on);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt selection, scanned from bit 0 upward so the highest ready index wins

  logic [31:0] irq_ready;
  logic irq_m_on;
  logic irq_s_on;

  always_comb
  begin
    // A lower mode always accepts interrupts aimed above it
    irq_m_on = (i_priv != mst_pkg::PRIV_M)
      || status[mst_pkg::ST_M_INT_EN];
    irq_s_on = (i_priv == mst_pkg::PRIV_U)
      || (i_priv == mst_pkg::PRIV_S && status[mst_pkg::ST_S_INT_EN]);
  end

  // Delegated bits answer to the supervisor enable, the rest to machine
  for (genvar b = 0; b < 32; b++)
  begin : g_irq_route
    assign irq_ready[b] = i_pending[b] && int_enable[b]
      && mst_pkg::IE_WMASK[b]
      && (int_deleg[b] ? irq_s_on : irq_m_on);
  end

  always_comb
  begin
    o_irq_take = 1'b0;
    o_irq_cause = 5'h00;
    o_irq_to_s = 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      if (irq_ready[k])
      begin
        o_irq_take = 1'b1;
        o_irq_cause = 5'(k);
        o_irq_to_s = int_deleg[k];
      end
    end
    // Machine external outranks every other source
    if (irq_ready[mst_pkg::IE_MEI])
    begin
      o_irq_cause = 5'(mst_pkg::IE_MEI);
      o_irq_to_s = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  always_comb
  begin
    next_status = status;
    next_isa = isa;
    next_exc_deleg = exc_deleg;
    next_int_deleg = int_deleg;
    next_int_enable = int_enable;
    if (i_wr)
    begin
      case (i_addr)
        mst_pkg::ADDR_STATUS:
        begin
          next_status = i_wdata & mst_pkg::STATUS_WMASK;
        end
        mst_pkg::ADDR_ISA:
        begin
          // Only legal widths and offered letters may be written
          if (i_wdata[mst_pkg::ISA_BASE_LO +: 2] == BASE_WIDTH)
          begin
            next_isa = {BASE_WIDTH, 4'h0,
              i_wdata[25:0] & EXTENSIONS};
          end
        end
        mst_pkg::ADDR_EXC_DELEG:
        begin
          next_exc_deleg = i_wdata;
        end
        mst_pkg::ADDR_INT_DELEG:
        begin
          next_int_deleg = i_wdata;
        end
        mst_pkg::ADDR_INT_ENABLE:
        begin
          next_int_enable = i_wdata
            & mst_pkg::IE_WMASK;
        end
        default:
        begin
          next_status = status;
        end
      endcase
    end
    // Hardware raises float state to dirty after the software write
    if (i_float_dirty)
    begin
      next_status[mst_pkg::ST_FLT_ST_LO +: 2] = mst_pkg::XST_DIRTY;
    end
    next_status[mst_pkg::ST_EXT_ST_LO +: 2] = i_ext_state;
    if (i_trap && o_trap_to_s)
    begin
      next_status[mst_pkg::ST_S_PRIOR] = i_priv[0];
      next_status[mst_pkg::ST_S_PRIOR_IE] =
        status[mst_pkg::ST_S_INT_EN];
      next_status[mst_pkg::ST_S_INT_EN] = 1'b0;
    end
    else if (i_trap)
    begin
      next_status[mst_pkg::ST_M_PRIOR_LO +: 2] = i_priv;
      next_status[mst_pkg::ST_M_PRIOR_IE] =
        status[mst_pkg::ST_M_INT_EN];
      next_status[mst_pkg::ST_M_INT_EN] = 1'b0;
    end
    else if (i_mret)
    begin
      next_status[mst_pkg::ST_M_INT_EN] = status[mst_pkg::ST_M_PRIOR_IE];
      next_status[mst_pkg::ST_M_PRIOR_IE] = 1'b1;
      next_status[mst_pkg::ST_M_PRIOR_LO +: 2] = mst_pkg::PRIV_U;
    end
    else if (i_sret)
    begin
      next_status[mst_pkg::ST_S_INT_EN] = status[mst_pkg::ST_S_PRIOR_IE];
      next_status[mst_pkg::ST_S_PRIOR_IE] = 1'b1;
      next_status[mst_pkg::ST_S_PRIOR] = 1'b0;
    end
    // Reserved prior-privilege code 2 is not kept
    if (next_status[mst_pkg::ST_M_PRIOR_LO +: 2] == 2'h2)
    begin
      next_status[mst_pkg::ST_M_PRIOR_LO +: 2] = mst_pkg::PRIV_U;
    end
  end

  always_comb
  begin
    // Summary dirty bit is derived on read, so it never goes stale
    status_rd = status;
    status_rd[mst_pkg::ST_ANY_DIRTY] =
      (status[mst_pkg::ST_FLT_ST_LO +: 2] == mst_pkg::XST_DIRTY)
      || (status[mst_pkg::ST_EXT_ST_LO +: 2] == mst_pkg::XST_DIRTY);
    next_rdata = 32'h00000000;
    if (i_rd)
    begin
      case (i_addr)
        mst_pkg::ADDR_STATUS:
        begin
          next_rdata = status_rd;
        end
        mst_pkg::ADDR_ISA:
        begin
          next_rdata = isa;
        end
        mst_pkg::ADDR_EXC_DELEG:
        begin
          next_rdata = exc_deleg;
        end
        mst_pkg::ADDR_INT_DELEG:
        begin
          next_rdata = int_deleg;
        end
        mst_pkg::ADDR_INT_ENABLE:
        begin
          next_rdata = int_enable;
        end
        default:
        begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // Read data idles at zero so a stale word never looks like an answer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      status <= mst_pkg::STATUS_RESET;
      isa <= mst_pkg::ISA_RESET;
      exc_deleg <= mst_pkg::DELEG_RESET;
      int_deleg <= mst_pkg::DELEG_RESET;
      int_enable <= mst_pkg::IE_RESET;
      rdata <= 32'h00000000;
    end
    else
    begin
      status <= next_status;
      isa <= next_isa;
      exc_deleg <= next_exc_deleg;
      int_deleg <= next_int_deleg;
      int_enable <= next_int_enable;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;

endmodule : mst_csr

/* File: verif/mst_csr_sva.sv */
// Port-level assertions for the machine status and trap registers
module mst_csr_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Hart state and checks
  input wire logic [1:0] i_priv,
  input wire logic i_trap,
  input wire logic i_satp_access,
  input wire logic i_vm_fence,
  input wire logic o_vm_illegal,
  input wire logic i_paging_on,
  input wire logic i_is_fetch,
  input wire logic [1:0] o_eff_priv,
  input wire logic o_access_fault,
  input wire logic o_trap_to_s
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_rdata_idle: assert property (
    !$past(i_rd) && !$past(i_reset) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  a_ie_rsvd: assert property ($past(i_rd) &&
    $past(i_addr) == mst_pkg::ADDR_INT_ENABLE |->
    (o_rdata & ~mst_pkg::IE_WMASK) == 32'h0) else $error("enable reserved");
  a_isa_rsvd: assert property ($past(i_rd) &&
    $past(i_addr) == mst_pkg::ADDR_ISA |-> o_rdata[29:26] == 4'h0)
    else $error("isa reserved bits set");
  a_status_rsvd: assert property ($past(i_rd) &&
    $past(i_addr) == mst_pkg::ADDR_STATUS |->
    (o_rdata & 32'h7F800644) == 32'h0) else $error("status reserved set");
  a_vm_op_priv: assert property (o_vm_illegal |->
    i_priv == mst_pkg::PRIV_S && (i_satp_access || i_vm_fence))
    else $error("vm operation refused outside rule");
  a_fetch_priv: assert property (
    i_is_fetch |-> o_eff_priv == i_priv)
    else $error("fetch uses modified privilege");
  a_bare_ok: assert property (!i_paging_on |-> !o_access_fault)
    else $error("fault without paging");
  a_m_nodeleg: assert property (
    i_trap && i_priv == mst_pkg::PRIV_M |-> !o_trap_to_s)
    else $error("machine trap delegated");
endmodule : mst_csr_sva

////////////////////////////////////////////////////////////////////////////////
bind mst_csr mst_csr_sva i_mst_csr_sva (.i_clk, .i_reset, .i_addr, .i_rd,
  .o_rdata, .i_priv, .i_trap, .i_satp_access, .i_vm_fence, .o_vm_illegal,
  .i_paging_on, .i_is_fetch, .o_eff_priv, .o_access_fault, .o_trap_to_s);

/* File: verif/mst_pipe_model.sv */
// Pipeline-side model issuing memory access requests
module mst_pipe_model (
  // Clock
  input wire logic i_clk,
  // Access request
  output logic [7:0] o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold = 1'b0;
  logic [31:0] r;

  initial o_req = 8'h00;

  // Idle traffic wanders so a stale level never looks meaningful
  always @(posedge i_clk)
  begin
    r = $urandom;
    if (!hold)
      o_req <= {r[0], 3'b100 >> (r[3:1] % 3), r[7:4]};
  end

  task automatic req(input logic [7:0] v);
    hold = 1'b1;
    o_req <= v;
  endtask : req

  task automatic free();
    hold = 1'b0;
  endtask : free
endmodule : mst_pipe_model

/* File: verif/tb_mst_csr.sv */
// Self-checking bench for the machine status and trap registers
module tb_mst_csr;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [11:0] i_addr = 12'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_priv = 2'h3;
  logic i_float_dirty = 1'b0;
  logic i_trap_irq = 1'b0;
  logic i_mret = 1'b0;
  logic i_sret = 1'b0;
  logic [1:0] i_ext_state = 2'h0;
  logic i_trap = 1'b0;
  logic [4:0] i_trap_cause = 5'h0;
  logic i_satp_access = 1'b0;
  logic i_vm_fence = 1'b0;
  logic [31:0] i_pending = 32'h0;
  logic [7:0] req;
  logic [31:0] o_rdata;
  logic o_trap_to_s, o_vm_illegal, o_access_fault, o_irq_take, o_irq_to_s;
  logic [1:0] o_next_priv, o_eff_priv;
  logic [4:0] o_irq_cause;
  int err_total = 0;
  int num_checks = 0;
  int k;
  logic [31:0] a, d;

  always #2 i_clk = ~i_clk;

  mst_csr i_mst_csr (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_priv, .i_float_dirty, .i_ext_state, .i_trap,
    .i_trap_irq, .i_trap_cause, .i_mret, .i_sret,
    .o_trap_to_s, .o_next_priv, .i_satp_access, .i_vm_fence, .o_vm_illegal,
    .i_paging_on(req[7]), .i_is_fetch(req[6]), .i_is_load(req[5]),
    .i_is_store(req[4]), .i_pte_r(req[3]), .i_pte_w(req[2]),
    .i_pte_x(req[1]), .i_pte_u(req[0]), .o_eff_priv, .o_access_fault,
    .i_pending, .o_irq_take, .o_irq_cause, .o_irq_to_s);
  mst_pipe_model i_mst_pipe_model (.i_clk, .o_req(req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [11:0] ad, input logic [31:0] dt);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= dt;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] m, e);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata & m, e);
  endtask : rd_chk

  task automatic take(input logic [1:0] p, input logic [4:0] c,
    input logic s, input logic [31:0] m, e);
    @(posedge i_clk);
    i_priv <= p;
    i_trap_cause <= c;
    i_trap <= 1'b1;
    #1 check(o_trap_to_s, s);
    check(o_next_priv, s ? mst_pkg::PRIV_S : mst_pkg::PRIV_M);
    @(posedge i_clk);
    i_trap <= 1'b0;
    rd_chk(mst_pkg::ADDR_STATUS, m, e);
  endtask : take

  task automatic ret(input logic m, input logic [1:0] p,
    input logic [31:0] msk, e);
    @(posedge i_clk);
    i_mret <= m;
    i_sret <= !m;
    #1 check(o_next_priv, p);
    @(posedge i_clk);
    i_mret <= 1'b0;
    i_sret <= 1'b0;
    rd_chk(mst_pkg::ADDR_STATUS, msk, e);
  endtask : ret

  function automatic logic [31:0] exp_reg(input logic [11:0] ad,
    input logic [31:0] dt);
    case (ad)
      mst_pkg::ADDR_INT_ENABLE: return dt & mst_pkg::IE_WMASK;
      mst_pkg::ADDR_EXC_DELEG, mst_pkg::ADDR_INT_DELEG: return dt;
      default: return 32'h0;
    endcase
  endfunction : exp_reg

  // Supervisor load: user page needs the access bit, and any page needs read, or exec with exec_readable
  function automatic logic exp_fault(input logic [6:0] s);
    return s[6] && ((s[5] && !s[1]) || !(s[3] || (s[0] && s[4])));
  endfunction : exp_fault

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #40000;
    err_total++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h1dab));
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    for (k = 0; k < 6; k++)
      rd_chk(12'h300 + k[11:0], '1, 32'h0);
    repeat (24)
    begin
      a = 32'h302 + $urandom % 4;
      d = $urandom;
      wr_reg(a[11:0], d);
      rd_chk(a[11:0], '1, exp_reg(a[11:0], d));
    end
    wr_reg(mst_pkg::ADDR_ISA, 32'hFFFFFFFF);
    rd_chk(mst_pkg::ADDR_ISA, '1, 32'h0);
    wr_reg(mst_pkg::ADDR_ISA, 32'h7FFFFFFF);
    rd_chk(mst_pkg::ADDR_ISA, '1, 32'h40141105);
    for (k = 0; k < 4; k++)
    begin
      i_ext_state <= k[1:0];
      rd_chk(mst_pkg::ADDR_STATUS, 32'h18000, 32'(k) << 15);
    end
    i_float_dirty <= 1'b1;
    rd_chk(mst_pkg::ADDR_STATUS, 32'h6000, 32'h6000);
    i_float_dirty <= 1'b0;
    for (k = 0; k < 16; k++)
    begin
      wr_reg(mst_pkg::ADDR_STATUS, {11'h0, k[0], 20'h0});
      i_priv <= k[1] ? mst_pkg::PRIV_S : mst_pkg::PRIV_U;
      {i_vm_fence, i_satp_access} <= k[3:2];
      #1 check(o_vm_illegal, k[0] & k[1] & (k[3:2] != 2'h0));
    end
    {i_vm_fence, i_satp_access} <= 2'h0;
    // Supervisor loads, directly or through modified privilege
    for (k = 0; k < 128; k++)
    begin
      // Request is held before edges pass, so idle traffic cannot race it
      i_priv <= k[2] ? mst_pkg::PRIV_M : mst_pkg::PRIV_S;
      i_mst_pipe_model.req({k[6], 3'b010, k[3], 1'b0, k[4], k[5]});
      wr_reg(mst_pkg::ADDR_STATUS,
        {12'h0, k[0], k[1], k[2], 4'h0, 1'b0, k[2], 11'h0});
      #1 check(o_eff_priv, mst_pkg::PRIV_S);
      check(o_access_fault, exp_fault(k[6:0]));
    end
    i_mst_pipe_model.req(8'hCF);
    #1 check(o_eff_priv, mst_pkg::PRIV_M);
    i_mst_pipe_model.req(8'h90);
    #1 check(o_access_fault, 1'b1);
    i_mst_pipe_model.free();
    wr_reg(mst_pkg::ADDR_EXC_DELEG, 32'h100);
    wr_reg(mst_pkg::ADDR_STATUS, 32'h0000000A);
    take(mst_pkg::PRIV_U, mst_pkg::CAUSE_ECALL_U, 1'b1, 32'h1AA, 32'h28);
    take(mst_pkg::PRIV_S, mst_pkg::CAUSE_ILLEGAL, 1'b0, 32'h1888, 32'h880);
    take(mst_pkg::PRIV_M, mst_pkg::CAUSE_ECALL_U, 1'b0, 32'h1800, 32'h1800);
    wr_reg(mst_pkg::ADDR_INT_DELEG, 32'h0);
    wr_reg(mst_pkg::ADDR_INT_ENABLE, 32'h80);
    i_pending <= 32'h80;
    for (k = 0; k < 2; k++)
    begin
      wr_reg(mst_pkg::ADDR_STATUS, {28'h0, k[0], 3'h0});
      i_priv <= mst_pkg::PRIV_M;
      #1 check(o_irq_take, k[0]);
    end
    check(o_irq_cause, 32'h7);
    i_pending <= 32'h20;
    wr_reg(mst_pkg::ADDR_INT_DELEG, 32'h20);
    wr_reg(mst_pkg::ADDR_INT_ENABLE, 32'hA0);
    i_priv <= mst_pkg::PRIV_U;
    #1 check(o_irq_take, 1'b1);
    check(o_irq_cause, 32'h5);
    check(o_irq_to_s, 1'b1);
    i_trap_irq <= 1'b1;
    take(mst_pkg::PRIV_S, 5'h05, 1'b1, 32'h100, 32'h100);
    i_trap_irq <= 1'b0;
    ret(1'b1, mst_pkg::PRIV_U, 32'h1888, 32'h80);
    ret(1'b0, mst_pkg::PRIV_S, 32'h122, 32'h20);
    wrap_up();
  end
endmodule : tb_mst_csr
